/* logic/reg_access_pkg.sv */
package reg_access_pkg;
    // Bus widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_EXOKAY = 2'h1;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Pages
    localparam logic [31:0] CFG_PAGE_BASE  = 32'h0000_0000;
    localparam logic [31:0] STAT_PAGE_BASE = 32'h0000_0200;
    localparam logic [31:0] STAT_PAGE_END  = 32'h0000_03FF;

    // Configuration register offsets
    localparam logic [31:0] OFS_CORE_VERSION       = 32'h0000_0000;
    localparam logic [31:0] OFS_TRANSCEIVER_RESET  = 32'h0000_0004;
    localparam logic [31:0] OFS_CORE_RESET_CONTROL = 32'h0000_0008;
    localparam logic [31:0] OFS_TRANSMIT_CONFIG    = 32'h0000_000C;
    localparam logic [31:0] OFS_TRANSMIT_DIAG      = 32'h0000_0010;
    localparam logic [31:0] OFS_RECEIVE_CONFIG     = 32'h0000_0014;
    localparam logic [31:0] OFS_LOOPBACK_CONTROL   = 32'h0000_0018;
    localparam logic [31:0] OFS_CFG_RESERVED_LO    = 32'h0000_001C;

    // Status page words
    localparam int          STAT_WORDS       = 256;
    localparam int          STAT_IDX_W       = 8;
    localparam logic [1:0]  WORD_ALIGN       = 2'h0;

    // Version fields, arbitrary values
    localparam logic [7:0]  VERSION_MINOR    = 8'h01;
    localparam logic [7:0]  VERSION_MAJOR    = 8'h01;
    localparam int          VER_MINOR_LSB    = 0;
    localparam int          VER_MAJOR_LSB    = 8;

    // Transceiver reset field
    localparam int          XCVR_RESET_BIT   = 0;

    localparam logic [31:0] CFG_RESET_VALUE  = 32'h0000_0000;
endpackage

/* logic/reg_access_if.sv */
`timescale 1ns/1ps
interface reg_access_if (
    input wire logic clk
);
    logic        bus_sync_reset;
    logic        stats_snapshot_pulse;
    logic [31:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;

    modport user (
        input  clk, awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
        output bus_sync_reset, stats_snapshot_pulse, awaddr, awvalid, wdata, wstrb, wvalid,
        output bready, araddr, arvalid, rready
    );
    modport regmap (
        input  clk, bus_sync_reset, stats_snapshot_pulse, awaddr, awvalid, wdata, wstrb, wvalid,
        input  bready, araddr, arvalid, rready,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
endinterface // reg_access_if

/* logic/reg_map_slave.sv */
`timescale 1ns/1ps
module reg_map_slave (
    // Bus
    reg_access_if.regmap                bus,
    // Clock enable
    input  wire logic                   ce,
    // Core control outputs
    output logic                        xcvr_reset_pulse,
    output logic [31:0]                 core_reset_ctl,
    output logic [31:0]                 tx_cfg,
    output logic [31:0]                 tx_diag_cfg,
    output logic [31:0]                 rx_cfg,
    output logic [31:0]                 loopback_ctl,
    // Core status
    input  wire logic [255:0][31:0]     stat_words,
    output logic                        stats_snapshot
);
    logic        aw_held_r;
    logic        w_held_r;
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_ok;
    logic [31:0] xcvr_reg;
    logic [31:0] stat_ofs;

    // Bits owned by the reconfiguration port, none by default
    localparam logic [31:0] RECONFIG_OWNED = 32'h0000_0000;

    assign bus.awready = ~aw_held_r & ~bus.bvalid;
    assign bus.wready  = ~w_held_r & ~bus.bvalid;
    assign bus.arready = ~bus.rvalid;
    assign xcvr_reg    = 32'h0;
    assign stat_ofs    = bus.araddr - reg_access_pkg::STAT_PAGE_BASE;

    // synchronous active-high reset on the bus clock
    always_ff @(posedge bus.clk) begin
        if (bus.bus_sync_reset) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 32'h0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
        end else if (ce) begin
            if (bus.awvalid && bus.awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= bus.awaddr;
            end
            if (bus.wvalid && bus.wready) begin
                w_held_r <= 1'b1;
                w_data_r <= bus.wdata;
                w_strb_r <= bus.wstrb;
            end
            if (aw_held_r && w_held_r) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end
        end
    end

    // writable words only, holes are reserved
    always_comb begin
        unique case (aw_addr_r)
            reg_access_pkg::OFS_TRANSCEIVER_RESET,
            reg_access_pkg::OFS_CORE_RESET_CONTROL,
            reg_access_pkg::OFS_TRANSMIT_CONFIG,
            reg_access_pkg::OFS_TRANSMIT_DIAG,
            reg_access_pkg::OFS_RECEIVE_CONFIG,
            reg_access_pkg::OFS_LOOPBACK_CONTROL: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) m[8*i +: 8] = nw[8*i +: 8];
        end
        return m & ~RECONFIG_OWNED;
    endfunction

    // configuration writes drive core controls; write response
    always_ff @(posedge bus.clk) begin
        if (bus.bus_sync_reset) begin
            bus.bvalid       <= 1'b0;
            bus.bresp        <= reg_access_pkg::RESP_OKAY;
            xcvr_reset_pulse <= 1'b0;
            core_reset_ctl   <= reg_access_pkg::CFG_RESET_VALUE;
            tx_cfg           <= reg_access_pkg::CFG_RESET_VALUE;
            tx_diag_cfg      <= reg_access_pkg::CFG_RESET_VALUE;
            rx_cfg           <= reg_access_pkg::CFG_RESET_VALUE;
            loopback_ctl     <= reg_access_pkg::CFG_RESET_VALUE;
        end else if (ce) begin
            xcvr_reset_pulse <= 1'b0;
            if (bus.bvalid && bus.bready) begin
                bus.bvalid <= 1'b0;
            end
            if (aw_held_r && w_held_r) begin
                bus.bvalid <= 1'b1;
                bus.bresp  <= wr_ok ? reg_access_pkg::RESP_OKAY : reg_access_pkg::RESP_SLVERR;
                if (wr_ok) begin
                    unique case (aw_addr_r)
                        reg_access_pkg::OFS_TRANSCEIVER_RESET: begin
                            xcvr_reset_pulse <= w_strb_r[0] & w_data_r[reg_access_pkg::XCVR_RESET_BIT];
                        end
                        reg_access_pkg::OFS_CORE_RESET_CONTROL: begin
                            core_reset_ctl <= merge(core_reset_ctl, w_data_r, w_strb_r);
                        end
                        reg_access_pkg::OFS_TRANSMIT_CONFIG: begin
                            tx_cfg <= merge(tx_cfg, w_data_r, w_strb_r);
                        end
                        reg_access_pkg::OFS_TRANSMIT_DIAG: begin
                            tx_diag_cfg <= merge(tx_diag_cfg, w_data_r, w_strb_r);
                        end
                        reg_access_pkg::OFS_RECEIVE_CONFIG: begin
                            rx_cfg <= merge(rx_cfg, w_data_r, w_strb_r);
                        end
                        default: begin
                            loopback_ctl <= merge(loopback_ctl, w_data_r, w_strb_r);
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge bus.clk) begin
        if (bus.bus_sync_reset) begin
            bus.rvalid     <= 1'b0;
            bus.rdata      <= 32'h0;
            bus.rresp      <= reg_access_pkg::RESP_OKAY;
            stats_snapshot <= 1'b0;
        end else if (ce) begin
            stats_snapshot <= bus.stats_snapshot_pulse;
            if (bus.rvalid && bus.rready) begin
                bus.rvalid <= 1'b0;
            end
            if (bus.arvalid && bus.arready) begin
                bus.rvalid <= 1'b1;
                bus.rresp  <= reg_access_pkg::RESP_OKAY;
                bus.rdata  <= 32'h0;
                if (bus.araddr[1:0] != reg_access_pkg::WORD_ALIGN) begin
                    bus.rresp <= reg_access_pkg::RESP_SLVERR;
                end else if (bus.araddr >= reg_access_pkg::STAT_PAGE_BASE &&
                             bus.araddr <= reg_access_pkg::STAT_PAGE_END) begin
                    bus.rdata <= stat_words[stat_ofs[reg_access_pkg::STAT_IDX_W+1:2]];
                end else begin
                    unique case (bus.araddr)
                        reg_access_pkg::OFS_CORE_VERSION: begin
                            bus.rdata <= {16'h0, reg_access_pkg::VERSION_MAJOR, reg_access_pkg::VERSION_MINOR};
                        end
                        reg_access_pkg::OFS_TRANSCEIVER_RESET:  bus.rdata <= xcvr_reg;
                        reg_access_pkg::OFS_CORE_RESET_CONTROL: bus.rdata <= core_reset_ctl;
                        reg_access_pkg::OFS_TRANSMIT_CONFIG:    bus.rdata <= tx_cfg;
                        reg_access_pkg::OFS_TRANSMIT_DIAG:      bus.rdata <= tx_diag_cfg;
                        reg_access_pkg::OFS_RECEIVE_CONFIG:     bus.rdata <= rx_cfg;
                        reg_access_pkg::OFS_LOOPBACK_CONTROL:   bus.rdata <= loopback_ctl;
                        default: bus.rresp <= reg_access_pkg::RESP_SLVERR;
                    endcase
                end
            end
        end
    end
endmodule // reg_map_slave

/* logic/reg_access_user.sv */
`timescale 1ns/1ps
module reg_access_user (
    // Bus
    reg_access_if.user                  bus,
    // Clock enable and reset
    input  wire logic                   ce,
    input  wire logic                   sreset,
    input  wire logic                   stats_tick,
    // User requests
    input  wire logic                   user_read_req,
    input  wire logic                   user_write_req,
    input  wire logic [31:0]            user_addr,
    input  wire logic [31:0]            user_wdata,
    input  wire logic [3:0]             user_wstrb,
    // User results
    output logic [31:0]                 user_rdata,
    output logic                        user_done,
    output logic                        write_error,
    output logic                        read_error
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_READ  = 4'b0100,
        ST_ACK   = 4'b1000
    } seq_state_e;

    seq_state_e  state_r;
    seq_state_e  state_nxt;
    logic        wr_start;
    logic        rd_start;

    // Read wins when both requests meet idle
    assign rd_start = (state_r == ST_IDLE) && user_read_req;
    assign wr_start = (state_r == ST_IDLE) && !user_read_req && user_write_req;

    // reset and tick are registered onto the bus, tick only while ce is high
    always_ff @(posedge bus.clk) begin
        bus.bus_sync_reset <= sreset;
    end

    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.stats_snapshot_pulse <= 1'b0;
        end else if (ce) begin
            bus.stats_snapshot_pulse <= stats_tick;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (user_read_req) begin
                    state_nxt = ST_READ;
                end else if (user_write_req) begin
                    state_nxt = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (bus.bvalid && bus.bready) begin
                    state_nxt = ST_ACK;
                end
            end
            ST_READ: begin
                if (bus.rvalid && bus.rready) begin
                    state_nxt = ST_ACK;
                end
            end
            ST_ACK: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Write address valid held until taken
    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.awvalid <= 1'b0;
        end else if (ce) begin
            if (wr_start) begin
                bus.awvalid <= 1'b1;
            end else if (bus.awvalid && bus.awready) begin
                bus.awvalid <= 1'b0;
            end
        end
    end

    // Write data valid held until taken
    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.wvalid <= 1'b0;
        end else if (ce) begin
            if (wr_start) begin
                bus.wvalid <= 1'b1;
            end else if (bus.wvalid && bus.wready) begin
                bus.wvalid <= 1'b0;
            end
        end
    end

    // Address, data and strobes latched at start
    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.awaddr <= 32'h0;
            bus.wdata  <= 32'h0;
            bus.wstrb  <= 4'h0;
        end else if (ce && wr_start) begin
            bus.awaddr <= user_addr;
            bus.wdata  <= user_wdata;
            bus.wstrb  <= user_wstrb;
        end
    end

    // Response ready held until response arrives
    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.bready <= 1'b0;
        end else if (ce) begin
            if (wr_start) begin
                bus.bready <= 1'b1;
            end else if (bus.bvalid && bus.bready) begin
                bus.bready <= 1'b0;
            end
        end
    end

    // Read address valid held until taken
    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.arvalid <= 1'b0;
        end else if (ce) begin
            if (rd_start) begin
                bus.arvalid <= 1'b1;
            end else if (bus.arvalid && bus.arready) begin
                bus.arvalid <= 1'b0;
            end
        end
    end

    // Read address latched at start
    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.araddr <= 32'h0;
        end else if (ce && rd_start) begin
            bus.araddr <= user_addr;
        end
    end

    // Read data ready held until data arrives
    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            bus.rready <= 1'b0;
        end else if (ce) begin
            if (rd_start) begin
                bus.rready <= 1'b1;
            end else if (bus.rvalid && bus.rready) begin
                bus.rready <= 1'b0;
            end
        end
    end

    always_ff @(posedge bus.clk) begin
        if (sreset) begin
            write_error <= 1'b0;
            read_error  <= 1'b0;
            user_done   <= 1'b0;
            user_rdata  <= 32'h0;
        end else if (ce) begin
            user_done   <= 1'b0;
            write_error <= 1'b0;
            read_error  <= 1'b0;
            if (state_r == ST_WRITE && bus.bvalid && bus.bready) begin
                user_done   <= 1'b1;
                write_error <= (bus.bresp == reg_access_pkg::RESP_SLVERR);
            end
            if (state_r == ST_READ && bus.rvalid && bus.rready) begin
                user_done  <= 1'b1;
                user_rdata <= bus.rdata;
                read_error <= (bus.rresp == reg_access_pkg::RESP_SLVERR);
            end
        end
    end
endmodule // reg_access_user

/* testbench/reg_access_monitor.sv */
`timescale 1ns/1ps
module reg_access_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        bus_sync_reset,
    input wire logic        stats_snapshot_pulse,
    // Write channels
    input wire logic [31:0] awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    // Read channels
    input wire logic [31:0] araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (bus_sync_reset);
    // Reserved, unmapped or misaligned word
    function automatic logic bad(input logic [31:0] a);
        return (a[1:0] != 2'h0) || (a >= 32'h400) || ((a >= 32'h1C) && (a < 32'h200));
    endfunction
    sequence s_aw_taken; awvalid && awready; endsequence
    sequence s_ar_taken; arvalid && arready; endsequence
    AST_AW_HOLD: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
        else $error("write address dropped early");
    AST_W_HOLD: assert property (wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wstrb))
        else $error("write data dropped early");
    AST_AR_HOLD: assert property (arvalid && !arready |=> arvalid && $stable(araddr))
        else $error("read address dropped early");
    AST_B_AFTER: assert property (s_aw_taken |-> ##[1:8] bvalid)
        else $error("no write response");
    AST_B_ERR: assert property (s_aw_taken ##0 bad(awaddr) |-> ##[1:8] (bvalid && bresp == 2'h2))
        else $error("bad write not refused");
    AST_R_AFTER: assert property (s_ar_taken |=> rvalid)
        else $error("no read data");
    AST_R_ERR: assert property (s_ar_taken ##0 bad(araddr) |=> rvalid && rresp == 2'h2)
        else $error("bad read not refused");
    AST_ONE_OWNER: assert property (awvalid |-> !arvalid)
        else $error("read and write at once");
    AST_BREADY: assert property (bvalid |-> bready)
        else $error("write response not accepted");
    AST_RREADY: assert property (rvalid |-> rready)
        else $error("read data not accepted");
    AST_SNAP: assert property (stats_snapshot_pulse |=> !stats_snapshot_pulse)
        else $error("snapshot pulse too long");
endmodule // reg_access_monitor

/* testbench/axi_lite_ctrl_stat_access_tb.sv */
`timescale 1ns/1ps
module axi_lite_ctrl_stat_access_tb;
    logic               clk;
    logic               sreset;
    logic               stats_tick;
    logic               ce;
    logic               user_read_req;
    logic               user_write_req;
    logic [31:0]        user_addr;
    logic [31:0]        user_wdata;
    logic [3:0]         user_wstrb;
    logic [31:0]        user_rdata;
    logic               user_done;
    logic               write_error;
    logic               read_error;
    logic               xcvr_reset_pulse;
    logic [31:0]        core_reset_ctl;
    logic [31:0]        tx_cfg;
    logic [31:0]        tx_diag_cfg;
    logic [31:0]        rx_cfg;
    logic [31:0]        loopback_ctl;
    logic [255:0][31:0] stat_words;
    logic               stats_snapshot;
    logic [31:0]        rdat;
    logic [31:0]        e;
    logic               werr;
    logic               rerr;
    logic [31:0]        bad_a [5];
    int                 fails;
    int                 checks;
    int                 xp;
    int                 sp;

    reg_access_if i_reg_access_if (.clk(clk));
    reg_access_user i_reg_access_user (
        .bus(i_reg_access_if.user), .ce(ce), .sreset(sreset), .stats_tick(stats_tick),
        .user_read_req(user_read_req), .user_write_req(user_write_req), .user_addr(user_addr),
        .user_wdata(user_wdata), .user_wstrb(user_wstrb), .user_rdata(user_rdata),
        .user_done(user_done), .write_error(write_error), .read_error(read_error)
    );
    reg_map_slave i_reg_map_slave (
        .bus(i_reg_access_if.regmap), .ce(ce), .xcvr_reset_pulse(xcvr_reset_pulse),
        .core_reset_ctl(core_reset_ctl), .tx_cfg(tx_cfg), .tx_diag_cfg(tx_diag_cfg), .rx_cfg(rx_cfg),
        .loopback_ctl(loopback_ctl), .stat_words(stat_words), .stats_snapshot(stats_snapshot)
    );
    reg_access_monitor i_mon (
        .clk(clk), .bus_sync_reset(i_reg_access_if.bus_sync_reset),
        .stats_snapshot_pulse(i_reg_access_if.stats_snapshot_pulse),
        .awaddr(i_reg_access_if.awaddr), .awvalid(i_reg_access_if.awvalid), .awready(i_reg_access_if.awready),
        .wdata(i_reg_access_if.wdata), .wstrb(i_reg_access_if.wstrb), .wvalid(i_reg_access_if.wvalid),
        .wready(i_reg_access_if.wready), .bresp(i_reg_access_if.bresp), .bvalid(i_reg_access_if.bvalid),
        .bready(i_reg_access_if.bready), .araddr(i_reg_access_if.araddr), .arvalid(i_reg_access_if.arvalid),
        .arready(i_reg_access_if.arready), .rdata(i_reg_access_if.rdata), .rresp(i_reg_access_if.rresp),
        .rvalid(i_reg_access_if.rvalid), .rready(i_reg_access_if.rready)
    );

    always #12.5 clk = ~clk;

    // Pulse counters
    always @(posedge clk) begin
        if (xcvr_reset_pulse === 1'b1) xp++;
        if (stats_snapshot === 1'b1) sp++;
    end

    function automatic logic [31:0] pat(input int i);
        return 32'h1357_9BDF + 32'(i) * 32'h0101_0101;
    endfunction

    task automatic wrap_up();
        $display("checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One user access, waits for done
    task automatic acc(input logic rd, input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        user_read_req <= rd;
        user_write_req <= wr;
        user_addr <= a;
        user_wdata <= d;
        user_wstrb <= s;
        @(posedge clk);
        user_read_req <= 1'b0;
        user_write_req <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (user_done !== 1'b1 && n < 40);
        if (user_done !== 1'b1) begin
            fails++;
            wrap_up();
        end
        rdat = user_rdata;
        werr = write_error;
        rerr = read_error;
    endtask

    initial begin
        clk = 1'b0;
        sreset = 1'b1;
        ce = 1'b1;
        stats_tick = 1'b0;
        user_read_req = 1'b0;
        user_write_req = 1'b0;
        user_addr = 32'h0;
        user_wdata = 32'h0;
        user_wstrb = 4'h0;
        fails = 0;
        checks = 0;
        bad_a = '{32'h0, 32'h1C, 32'h1FC, 32'h400, 32'hE};
        for (int i = 0; i < 256; i++) stat_words[i] = 32'h5000_0000 + 32'(i);
        repeat (4) @(posedge clk);
        sreset <= 1'b0;
        repeat (2) @(posedge clk);
        chk(tx_cfg, reg_access_pkg::CFG_RESET_VALUE);
        chk(loopback_ctl, reg_access_pkg::CFG_RESET_VALUE);
        acc(1'b1, 1'b0, reg_access_pkg::OFS_CORE_VERSION, 32'h0, 4'h0);
        chk(rdat, {16'h0000, reg_access_pkg::VERSION_MAJOR, reg_access_pkg::VERSION_MINOR});
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, 1'b1, 32'h8 + 32'(4 * i), pat(i), 4'hF);
            chk({30'h0, werr, rerr}, 32'h0);
            acc(1'b1, 1'b0, 32'h8 + 32'(4 * i), 32'h0, 4'h0);
            chk(rdat, pat(i));
        end
        chk(core_reset_ctl, pat(0));
        chk(tx_cfg, pat(1));
        chk(tx_diag_cfg, pat(2));
        chk(rx_cfg, pat(3));
        chk(loopback_ctl, pat(4));
        acc(1'b0, 1'b1, reg_access_pkg::OFS_TRANSMIT_CONFIG, 32'h1122_3344, 4'b0100);
        e = pat(1);
        e[23:16] = 8'h22;
        chk(tx_cfg, e);
        acc(1'b1, 1'b1, reg_access_pkg::OFS_RECEIVE_CONFIG, 32'hDEAD_BEEF, 4'hF);
        chk(rdat, pat(3));
        chk(rx_cfg, pat(3));
        xp = 0;
        acc(1'b0, 1'b1, reg_access_pkg::OFS_TRANSCEIVER_RESET, 32'h1, 4'hF);
        repeat (3) @(posedge clk);
        chk(32'(xp), 32'h1);
        acc(1'b1, 1'b0, reg_access_pkg::OFS_TRANSCEIVER_RESET, 32'h0, 4'h0);
        chk({31'h0, rdat[0]}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, 1'b1, bad_a[i], 32'hFFFF_FFFF, 4'hF);
            chk({30'h0, werr, rerr}, 32'h2);
            if (i > 0) begin
                acc(1'b1, 1'b0, bad_a[i], 32'h0, 4'h0);
                chk({30'h0, werr, rerr}, 32'h1);
            end
        end
        chk(tx_diag_cfg, pat(2));
        acc(1'b1, 1'b0, reg_access_pkg::STAT_PAGE_BASE, 32'h0, 4'h0);
        chk(rdat, stat_words[0]);
        acc(1'b1, 1'b0, 32'h3FC, 32'h0, 4'h0);
        chk(rdat, stat_words[127]);
        stat_words[9] <= 32'hFEED_0009;
        acc(1'b1, 1'b0, 32'h224, 32'h0, 4'h0);
        chk(rdat, 32'hFEED_0009);
        sp = 0;
        @(posedge clk);
        ce <= 1'b0;
        stats_tick <= 1'b1;
        @(posedge clk);
        stats_tick <= 1'b0;
        repeat (5) @(posedge clk);
        chk(32'(sp), 32'h0);
        ce <= 1'b1;
        @(posedge clk);
        stats_tick <= 1'b1;
        @(posedge clk);
        stats_tick <= 1'b0;
        repeat (5) @(posedge clk);
        chk(32'(sp), 32'h1);
        wrap_up();
    end
endmodule // axi_lite_ctrl_stat_access_tb
